// *** lockclr_pkg.sv ***
// package for the lock-bit clearing host controller
// assumes an 8-bit command path to a parallel nor flash device
package lockclr_pkg;

  // flash command codes
  localparam logic [7:0] cmd_setup        = 8'h60;
  localparam logic [7:0] cmd_confirm      = 8'hd0;
  localparam logic [7:0] cmd_read_array   = 8'hff;
  localparam logic [7:0] cmd_read_flags   = 8'h70;
  localparam logic [7:0] cmd_clear_flags  = 8'h50;

  // flag register bit positions
  localparam int bit_ready   = 7;
  localparam int bit_clr_err = 5;
  localparam int bit_seq_err = 4;
  localparam int bit_volt    = 3;

  // own register offsets (word index on the plain port)
  localparam logic [3:0] reg_ctrl   = 4'h0;
  localparam logic [3:0] reg_status = 4'h1;
  localparam logic [3:0] reg_irq    = 4'h2;
  localparam logic [3:0] reg_mask   = 4'h3;
  localparam logic [3:0] reg_flags  = 4'h4;

  // event bit positions in irq status / mask
  localparam int ev_done  = 0;
  localparam int ev_volt  = 1;
  localparam int ev_seq   = 2;
  localparam int ev_clr   = 3;

  // bus cycle timing on the flash pins, in sys_clk cycles
  localparam real        clk_ns        = 40.0;
  localparam real        t_we_ns       = 70.0;   // least write strobe width
  localparam real        t_rd_ns       = 150.0;  // least read access
  localparam logic [3:0] we_cycles     = 4'(int'($ceil(t_we_ns / clk_ns)));
  localparam logic [3:0] rd_cycles     = 4'(int'($ceil(t_rd_ns / clk_ns)));

  // reset values
  localparam logic [3:0] mask_reset = 4'h0;

  typedef enum logic [3:0] {
    st_idle    = 4'b0000,
    st_setup   = 4'b0001,
    st_confirm = 4'b0010,
    st_poll    = 4'b0011,
    st_check   = 4'b0100,
    st_array   = 4'b0101,
    st_clrflag = 4'b0110,
    st_gap     = 4'b0111
  } seq_state_t;

  // flash pin bundle driven by the controller
  typedef struct packed {
    logic       ce_n;
    logic       oe_n;
    logic       we_n;
    logic [7:0] dq_out;
    logic       dq_oe_n;
  } flash_drive_t;

endpackage : lockclr_pkg

// *** lockclr_host.sv ***
// host controller clearing all block lock-bits of a nor flash
// assumes one flash on an 8-bit data bus and software on a plain register port
`timescale 1ns/1ps
module lockclr_host
  import lockclr_pkg::*;
(
  input  wire logic       sys_clk,
  input  wire logic       rstn,
  input  wire logic [3:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic       wr,
  input  wire logic       rd,
  output logic      [7:0] rdata,
  output logic            irq,
  output logic            flash_ce_n,
  output logic            flash_oe_n,
  output logic            flash_we_n,
  output logic      [7:0] flash_dq_out,
  output logic            flash_dq_oe_n,
  input  wire logic [7:0] flash_dq_in,
  input  wire logic       flash_sts
);

  // flash data and indicator pins are synchronised before use
  logic [7:0]   dq_s1;
  logic [7:0]   dq_s2;
  logic         sts_s1;
  logic         sts_s2;
  seq_state_t   state;
  seq_state_t   next_state;
  seq_state_t   after_gap;
  logic [3:0]   cnt;
  logic         phase;
  logic [7:0]   flags;
  logic [3:0]   irq_stat;
  logic [3:0]   irq_mask;
  logic         busy;
  logic         want_clr;
  flash_drive_t drv;

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      dq_s1  <= 8'h00;
      dq_s2  <= 8'h00;
      sts_s1 <= 1'b1;
      sts_s2 <= 1'b1;
    end else begin
      dq_s1  <= flash_dq_in;
      dq_s2  <= dq_s1;
      sts_s1 <= flash_sts;
      sts_s2 <= sts_s1;
    end
  end

  // register port decode
  wire wr_ctrl  = wr && (addr == reg_ctrl);
  wire wr_irq   = wr && (addr == reg_irq);
  wire wr_mask  = wr && (addr == reg_mask);
  wire go       = wr_ctrl && wdata[0] && !busy;
  wire go_clr   = wr_ctrl && wdata[1] && !busy;   // clear-flags request
  wire cnt_done = (cnt == 4'h0);
  wire step     = cnt_done && phase;              // end of one pin cycle

  // live ready bit for polling; errors decoded from the captured byte, volt first
  wire f_ready = dq_s2[bit_ready];
  wire e_volt  = flags[bit_volt];
  wire e_seq   = !e_volt && flags[bit_seq_err] && flags[bit_clr_err];
  wire e_clr   = !e_volt && !flags[bit_seq_err] && flags[bit_clr_err];

  // sequencer next state
  always_comb begin
    next_state = state;
    unique case (state)
      st_idle:    if (go) next_state = st_setup;
                  else if (go_clr) next_state = st_clrflag;
      st_setup:   if (step) next_state = st_gap;
      st_confirm: if (step) next_state = st_poll;
      st_poll:    if (step && f_ready && sts_s2) next_state = st_check;
      st_check:   next_state = st_array;
      st_array:   if (step) next_state = st_idle;
      st_clrflag: if (step) next_state = st_idle;
      st_gap:     if (cnt_done) next_state = after_gap;
      default:    next_state = st_idle;
    endcase
  end

  // pin cycle timing: phase 0 write strobe active, phase 1 recovery; the read strobe stays active through both phases
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      state     <= st_idle;
      after_gap <= st_idle;
      cnt       <= 4'h0;
      phase     <= 1'b0;
    end else begin
      state <= next_state;
      if (next_state != state) begin
        phase <= 1'b0;
        cnt   <= (next_state == st_poll) ? rd_cycles : we_cycles;
        if (state == st_setup) after_gap <= st_confirm;
      end else if (cnt_done) begin
        phase <= ~phase;
        cnt   <= (state == st_poll) ? rd_cycles : we_cycles;
      end else begin
        cnt <= cnt - 4'h1;
      end
    end
  end

  // pin drive: writes for command states, reads while polling
  wire in_write = (state == st_setup) || (state == st_confirm) || (state == st_array) || (state == st_clrflag);
  wire in_read  = (state == st_poll);
  always_comb begin
    drv.ce_n    = !(in_write || in_read);
    drv.we_n    = !(in_write && !phase);
    drv.oe_n    = !in_read;
    drv.dq_oe_n = !in_write;
    unique case (state)
      st_setup:   drv.dq_out = cmd_setup;
      st_confirm: drv.dq_out = cmd_confirm;
      st_array:   drv.dq_out = cmd_read_array;
      st_clrflag: drv.dq_out = cmd_clear_flags;
      default:    drv.dq_out = 8'h00;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      flash_ce_n    <= 1'b1;
      flash_oe_n    <= 1'b1;
      flash_we_n    <= 1'b1;
      flash_dq_out  <= 8'h00;
      flash_dq_oe_n <= 1'b1;
    end else begin
      flash_ce_n    <= drv.ce_n;
      flash_oe_n    <= drv.oe_n;
      flash_we_n    <= drv.we_n;
      flash_dq_out  <= drv.dq_out;
      flash_dq_oe_n <= drv.dq_oe_n;
    end
  end

  // captured flags and busy
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      flags    <= 8'h00;
      busy     <= 1'b0;
      want_clr <= 1'b0;
    end else begin
      busy <= (next_state != st_idle);
      if (state == st_poll && step) flags <= dq_s2;
      if (state == st_check) want_clr <= e_volt || e_seq || e_clr;
      else if (state == st_clrflag && step) want_clr <= 1'b0;
    end
  end

  // sticky events, set wins over write-one-clear
  wire [3:0] ev;
  assign ev[ev_done] = (state == st_array) && step;
  assign ev[ev_volt] = (state == st_check) && e_volt;
  assign ev[ev_seq]  = (state == st_check) && e_seq;
  assign ev[ev_clr]  = (state == st_check) && e_clr;

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      irq_stat <= 4'h0;
      irq_mask <= mask_reset;
      irq      <= 1'b0;
    end else begin
      irq_stat <= (irq_stat & ~(wr_irq ? wdata[3:0] : 4'h0)) | ev;
      if (wr_mask) irq_mask <= wdata[3:0];
      irq <= |(irq_stat & irq_mask);
    end
  end

  // read mux, data one cycle after the strobe
  wire [7:0] rd_mux =
    (addr == reg_status) ? {5'h00, want_clr, flags[bit_ready], busy} :
    (addr == reg_irq)    ? {4'h0, irq_stat} :
    (addr == reg_mask)   ? {4'h0, irq_mask} :
    (addr == reg_flags)  ? flags : 8'h00;

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) rdata <= 8'h00;
    else       rdata <= rd ? rd_mux : 8'h00;
  end

endmodule : lockclr_host

// *** lockclr_host_asserts.sv ***
// checker for the lock-bit clearing host
// assumes it is bound onto lockclr_host, one clock domain
`timescale 1ns/1ps
module lockclr_host_asserts
  import lockclr_pkg::*;
(
  input wire logic       sys_clk,
  input wire logic       rstn,
  input wire logic       rd,
  input wire logic [7:0] rdata,
  input wire logic       flash_ce_n,
  input wire logic       flash_oe_n,
  input wire logic       flash_we_n,
  input wire logic [7:0] flash_dq_out,
  input wire logic       flash_dq_oe_n
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  logic [7:0] last_cmd;
  // last command byte written to the flash
  always_ff @(posedge sys_clk or negedge rstn)
    if (!rstn) last_cmd <= 8'h00;
    else if ($rose(flash_we_n)) last_cmd <= $past(flash_dq_out);
  // command order and pin timing
  setup_first_a: assert property ($rose(flash_we_n) && $past(flash_dq_out) == cmd_confirm |->
    last_cmd == cmd_setup) else $error("confirm without setup");
  array_after_a: assert property ($rose(flash_we_n) && last_cmd == cmd_confirm |->
    $past(flash_dq_out) == cmd_read_array) else $error("no read array");
  we_width_a: assert property ($fell(flash_we_n) |-> !flash_we_n [*3] ##1 flash_we_n)
    else $error("write width");
  write_drive_a: assert property (!flash_we_n |-> !flash_dq_oe_n && !flash_ce_n)
    else $error("write not driven");
  cmd_hold_a: assert property (!flash_we_n && !$past(flash_we_n) |-> $stable(flash_dq_out))
    else $error("command moved");
  no_contend_a: assert property (!flash_oe_n |-> flash_dq_oe_n && flash_we_n && !flash_ce_n)
    else $error("read contention");
  read_width_a: assert property ($fell(flash_oe_n) |-> !flash_oe_n [*5])
    else $error("read width");
  rdata_idle_a: assert property (!$past(rd) |-> rdata == 8'h00)
    else $error("rdata not idle");
endmodule : lockclr_host_asserts
bind lockclr_host lockclr_host_asserts chk (.sys_clk(sys_clk), .rstn(rstn), .rd(rd), .rdata(rdata),
  .flash_ce_n(flash_ce_n), .flash_oe_n(flash_oe_n), .flash_we_n(flash_we_n),
  .flash_dq_out(flash_dq_out), .flash_dq_oe_n(flash_dq_oe_n));

// *** nor_flash_model.sv ***
// behavioural nor flash for the lock-bit clearing host
// assumes the host pins; err picks an injected fault
`timescale 1ns/1ps
module nor_flash_model (
  input  wire logic       sys_clk,
  input  wire logic       rstn,
  input  wire logic       ce_n,
  input  wire logic       oe_n,
  input  wire logic       we_n,
  input  wire logic [7:0] dq,
  input  wire logic [1:0] err,
  output logic      [7:0] dq_in,
  output logic            sts
);
  logic [7:0] fr;
  logic       armed;
  logic       rd_flags;
  logic       pw;
  int         busy;
  // command decoder, busy timer and fault injection
  always @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      fr <= 8'h80;
      armed <= 0;
      rd_flags <= 0;
      busy <= 0;
      pw <= 1;
    end else begin
      pw <= we_n;
      if (busy == 1) fr <= fr | {2'b10, err[1], err == 3, err == 1, 3'h0};
      if (busy > 0) busy <= busy - 1;
      if (we_n && !pw && !ce_n) begin
        armed <= dq == 8'h60;
        rd_flags <= dq != 8'hff;
        if (armed && dq == 8'hd0) begin
          busy <= 20;
          fr <= fr & 8'h38;
        end
        if (dq == 8'h50) fr <= 8'h80;
      end
    end
  end
  // pulled-up ready line, released bus shows inverse
  assign sts = busy == 0;
  assign dq_in = !ce_n && !oe_n ? (rd_flags ? fr : 8'h00) : ~fr;
endmodule : nor_flash_model

// *** lockclr_host_tb.sv ***
// testbench for the lock-bit clearing host
// assumes nor_flash_model on the pins and the bound checker
`timescale 1ns/1ps
module lockclr_host_tb
  import lockclr_pkg::*;
;
  logic       sys_clk = 0, rstn = 0, wr = 0, rd = 0, irq, ce_n, oe_n, we_n, dq_oe_n, sts;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00, rdata, dq_out, mdq;
  logic [1:0] err = 2'h0;
  int         num_errors = 0, num_checks = 0;
  wire  [7:0] dq_in = dq_oe_n ? mdq : dq_out;
  always #20 sys_clk = ~sys_clk;
  lockclr_host dut (.sys_clk(sys_clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .irq(irq), .flash_ce_n(ce_n), .flash_oe_n(oe_n), .flash_we_n(we_n),
    .flash_dq_out(dq_out), .flash_dq_oe_n(dq_oe_n), .flash_dq_in(dq_in), .flash_sts(sts));
  nor_flash_model flash (.sys_clk(sys_clk), .rstn(rstn), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n),
    .dq(dq_out), .err(err), .dq_in(mdq), .sts(sts));
  // compare and bus cycles
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %0t %h %h", $time, got, exp);
    end
  endtask : chk
  task automatic wreg(input logic [3:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    addr <= a;
    wdata <= d;
    wr <= 1;
    @(posedge sys_clk);
    wr <= 0;
  endtask : wreg
  task automatic rreg(input logic [3:0] a, output logic [7:0] v);
    @(posedge sys_clk);
    addr <= a;
    rd <= 1;
    @(posedge sys_clk);
    rd <= 0;
    #1 v = rdata;
  endtask : rreg
  task automatic rc(input logic [3:0] a, input logic [7:0] e);
    logic [7:0] v;
    rreg(a, v);
    chk(v, e);
  endtask : rc
  // poll busy under a bound, then start and wait
  task automatic wait_idle;
    logic [7:0] v = 8'h01;
    repeat (2) @(posedge sys_clk);
    for (int i = 0; i < 200 && v[0] !== 1'b0; i++) rreg(reg_status, v);
    chk(v & 8'h01, 8'h00);
  endtask : wait_idle
  task automatic run(input logic [1:0] m);
    err <= m;
    wreg(reg_ctrl, 8'h01);
    wait_idle();
  endtask : run
  // masked event keeps irq low until unmasked
  task automatic s_mask;
    wreg(reg_mask, 8'h00);
    run(2'h0);
    chk({7'h0, irq}, 8'h00);
    wreg(reg_mask, 8'h01);
    @(posedge sys_clk);
    #1 chk({7'h0, irq}, 8'h01);
    wreg(reg_irq, 8'h0f);
  endtask : s_mask
  // clean clear, array mode restored, irq cleared
  task automatic s_clean;
    wreg(reg_mask, 8'h0f);
    run(2'h0);
    rc(reg_flags, 8'h80);
    rc(reg_irq, 8'h01);
    chk({7'h0, flash.rd_flags}, 8'h00);
    wreg(reg_irq, 8'h0f);
    rc(reg_irq, 8'h00);
    chk({7'h0, irq}, 8'h00);
  endtask : s_clean
  // each fault decoded, sticky until clear flags
  task automatic s_faults;
    logic [7:0] fl [3] = '{8'h08, 8'h20, 8'h30};
    logic [7:0] ev [3] = '{8'h02, 8'h08, 8'h04};
    for (int m = 1; m < 4; m++) begin
      run(2'(m));
      rc(reg_flags, 8'h80 | fl[m-1]);
      rc(reg_irq, 8'h01 | ev[m-1]);
      rc(reg_status, 8'h06);
      run(2'h0);
      rc(reg_flags, 8'h80 | fl[m-1]);
      wreg(reg_ctrl, 8'h02);
      wait_idle();
      run(2'h0);
      rc(reg_flags, 8'h80);
      wreg(reg_irq, 8'h0f);
    end
  endtask : s_faults
  task automatic print_verdict;
    if (num_errors == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : print_verdict
  initial begin
    repeat (16) @(posedge sys_clk);
    rstn <= 1;
    rc(reg_mask, {4'h0, mask_reset});
    rc(4'hf, 8'h00);
    s_mask();
    s_clean();
    s_faults();
    print_verdict();
  end
  // watchdog against a hang
  initial begin
    #2000000;
    num_errors++;
    print_verdict();
  end
endmodule : lockclr_host_tb
